/* hw/lcd_pkg.sv */
// Shared constants and types of the line decoder and loss-of-signal monitor.
package lcd_pkg;

  // ----------------------------------------------------------------
  // Decoder window and zero-run limits
  // ----------------------------------------------------------------
  localparam int         LCD_WIN_DEPTH     = 8;
  localparam logic [6:0] LCD_EXZ_AMI_ANSI  = 7'h0F;
  localparam logic [6:0] LCD_EXZ_AMI_FCC   = 7'h50;
  localparam logic [6:0] LCD_EXZ_B8ZS      = 7'h07;
  localparam logic [6:0] LCD_EXZ_HDB3      = 7'h03;
  localparam logic [6:0] LCD_ZRUN_MAX      = 7'h7F;
  localparam logic [1:0] LCD_COUNT_ON      = 2'h1;
  localparam logic [7:0] LCD_COUNT_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Loss-of-signal limits, in bit intervals
  // ----------------------------------------------------------------
  localparam logic [11:0] LCD_LOS_T1_SHORT = 12'h0AF;
  localparam logic [11:0] LCD_LOS_T1_LONG  = 12'h608;
  localparam logic [11:0] LCD_LOS_E1_SHORT = 12'h020;
  localparam logic [11:0] LCD_LOS_E1_LONG  = 12'h800;
  localparam logic [11:0] LCD_LOS_RUN_MAX  = 12'hFFF;
  localparam logic [7:0]  LCD_WIN_T1       = 8'h80;
  localparam logic [7:0]  LCD_WIN_E1       = 8'h20;
  localparam logic [7:0]  LCD_MARKS_T1     = 8'h10;
  localparam logic [7:0]  LCD_MARKS_E1     = 8'h04;
  localparam logic [7:0]  LCD_ZLIM_T1      = 8'h64;
  localparam logic [7:0]  LCD_ZLIM_E1      = 8'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LCD_AMI  = 2'b00,
    LCD_B8ZS = 2'b01,
    LCD_HDB3 = 2'b10
  } lcd_code_t;

  typedef enum logic [0:0] {
    LCD_LOS_IDLE = 1'b0,
    LCD_LOS_LOST = 1'b1
  } lcd_los_state_t;

  typedef struct packed {
    logic mark;
    logic pol;
    logic viol;
  } lcd_sym_t;

  typedef struct packed {
    logic count_overflow;
    logic violation;
    logic zero_run;
    logic signal_loss;
  } lcd_flags_t;

endpackage

/* hw/lcd_los_monitor.sv */
// Loss-of-signal declare and clear monitor working per received bit.
`timescale 1ns/10ps
module lcd_los_monitor
  import lcd_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic bit_en_i,
  input  wire logic e1_mode_i,
  input  wire logic criteria_i,
  input  wire logic amp_low_i,
  input  wire logic amp_ok_i,
  input  wire logic mark_i,
  output logic      los_o
);

  lcd_los_state_t state_reg;
  logic [11:0]    low_run_reg;
  logic [7:0]     win_cnt_reg;
  logic [7:0]     marks_reg;
  logic [7:0]     zrun_reg;
  logic           win_ok_reg;
  logic [11:0]    low_run_next;
  logic [11:0]    declare_lim;
  logic [7:0]     win_len;
  logic [7:0]     mark_lim;
  logic [7:0]     zero_lim;
  logic [7:0]     marks_next;
  logic [7:0]     zrun_next;
  logic           ok_next;

  // ----------------------------------------------------------------
  // Limits and per-bit arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    if (e1_mode_i) begin
      declare_lim = criteria_i ? LCD_LOS_E1_LONG : LCD_LOS_E1_SHORT;
      win_len     = LCD_WIN_E1;
      mark_lim    = LCD_MARKS_E1;
      zero_lim    = LCD_ZLIM_E1;
    end else begin
      declare_lim = criteria_i ? LCD_LOS_T1_LONG : LCD_LOS_T1_SHORT;
      win_len     = LCD_WIN_T1;
      mark_lim    = LCD_MARKS_T1;
      zero_lim    = LCD_ZLIM_T1;
    end
    if (!amp_low_i) begin
      low_run_next = 12'h000;
    end else if (low_run_reg == LCD_LOS_RUN_MAX) begin
      low_run_next = low_run_reg;
    end else begin
      low_run_next = low_run_reg + 12'h001;
    end
    marks_next = mark_i ? marks_reg + 8'h01 : marks_reg;
    zrun_next  = mark_i ? 8'h00 : zrun_reg + 8'h01;
    ok_next    = win_ok_reg && amp_ok_i && (zrun_next < zero_lim);
  end

  // ----------------------------------------------------------------
  // Declare and clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg   <= LCD_LOS_IDLE;
      low_run_reg <= 12'h000;
      win_cnt_reg <= 8'h00;
      marks_reg   <= 8'h00;
      zrun_reg    <= 8'h00;
      win_ok_reg  <= 1'b1;
    end else if (bit_en_i) begin
      low_run_reg <= low_run_next;
      case (state_reg)
        LCD_LOS_IDLE: begin
          win_cnt_reg <= 8'h00;
          marks_reg   <= 8'h00;
          zrun_reg    <= 8'h00;
          win_ok_reg  <= 1'b1;
          if (low_run_next >= declare_lim) begin
            state_reg <= LCD_LOS_LOST;
          end
        end
        LCD_LOS_LOST: begin
          if (win_cnt_reg == win_len - 8'h01) begin
            win_cnt_reg <= 8'h00;
            marks_reg   <= 8'h00;
            zrun_reg    <= 8'h00;
            win_ok_reg  <= 1'b1;
            if (ok_next && (marks_next >= mark_lim)) begin
              state_reg <= LCD_LOS_IDLE;
            end
          end else begin
            win_cnt_reg <= win_cnt_reg + 8'h01;
            marks_reg   <= marks_next;
            zrun_reg    <= zrun_next;
            win_ok_reg  <= ok_next;
          end
        end
        default: begin
          state_reg <= LCD_LOS_IDLE;
        end
      endcase
    end
  end

  assign los_o = (state_reg == LCD_LOS_LOST);

endmodule

/* hw/lcd_line_decoder.sv */
// Line code decoder with violation, zero-run and loss-of-signal reporting.
`timescale 1ns/10ps
module lcd_line_decoder
  import lcd_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   bit_en_i,
  input  wire logic                   rx_pos_i,
  input  wire logic                   rx_neg_i,
  input  wire logic                   e1_mode_i,
  input  wire logic                   line_code_select_i,
  input  wire logic                   zero_limit_standard_select_i,
  input  wire logic [1:0]             error_count_select_i,
  input  wire logic                   report_mode_select_i,
  input  wire logic                   count_transfer_request_i,
  input  wire logic                   second_tick_i,
  input  wire logic                   signal_loss_criteria_select_i,
  input  wire logic                   signal_loss_edge_select_i,
  input  wire logic                   all_ones_insert_i,
  input  wire logic                   amp_low_i,
  input  wire logic                   amp_ok_i,
  input  wire lcd_flags_t             irq_enable_i,
  input  wire lcd_flags_t             status_clear_i,
  output logic                        data_o,
  output logic                        data_valid_o,
  output logic                        bpv_event_o,
  output logic                        cv_event_o,
  output logic                        exz_event_o,
  output logic [COUNT_WIDTH/2-1:0]    count_low_o,
  output logic [COUNT_WIDTH/2-1:0]    count_high_o,
  output lcd_flags_t                  status_o,
  output logic                        signal_loss_state_o,
  output logic                        irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] sat_inc(input logic [6:0] value);
    sat_inc = (value == LCD_ZRUN_MAX) ? value : value + 7'h01;
  endfunction

  function automatic logic is_mark(input lcd_sym_t sym);
    is_mark = sym.mark;
  endfunction

  function automatic logic is_viol(input lcd_sym_t sym);
    is_viol = sym.mark && sym.viol;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lcd_sym_t                    win_reg [LCD_WIN_DEPTH];
  lcd_sym_t                    win_next [LCD_WIN_DEPTH];
  lcd_sym_t                    sym_in;
  lcd_sym_t                    sym_out;
  lcd_code_t                   code;
  logic                        last_pol_reg;
  logic                        hdb_viol_reg;
  logic [6:0]                  zrun_reg;
  logic [6:0]                  zrun_next;
  logic [6:0]                  exz_limit;
  logic [COUNT_WIDTH-1:0]      count_reg;
  logic                        trf_prev_reg;
  logic                        los_prev_reg;
  logic                        los_w;
  logic                        b8zs_hit;
  logic                        hdb3_hit;
  logic                        bpv_now;
  logic                        cv_now;
  logic                        exz_now;
  logic                        copy_now;
  logic                        count_ev;
  logic                        ovf_now;
  logic                        los_edge;
  lcd_flags_t                  set_now;
  lcd_flags_t                  status_next;

  // ----------------------------------------------------------------
  // Symbol capture and code selection
  // ----------------------------------------------------------------
  always_comb begin
    sym_in.mark = rx_pos_i || rx_neg_i;
    sym_in.pol  = rx_pos_i;
    sym_in.viol = sym_in.mark && (rx_pos_i == last_pol_reg);
    if (!line_code_select_i) begin
      code = LCD_AMI;
    end else if (e1_mode_i) begin
      code = LCD_HDB3;
    end else begin
      code = LCD_B8ZS;
    end
    sym_out = win_reg[LCD_WIN_DEPTH-1];
  end

  // ----------------------------------------------------------------
  // Substitution recognition
  // ----------------------------------------------------------------
  always_comb begin
    win_next[0] = sym_in;
    for (int i = 1; i < LCD_WIN_DEPTH; i++) begin
      win_next[i] = win_reg[i-1];
    end
    b8zs_hit = !is_mark(win_next[7]) && !is_mark(win_next[6]) && !is_mark(win_next[5])
               && is_viol(win_next[4])
               && win_next[3].mark && !win_next[3].viol
               && (win_next[3].pol != win_next[4].pol)
               && !is_mark(win_next[2])
               && is_viol(win_next[1])
               && (win_next[1].pol == win_next[3].pol)
               && win_next[0].mark && !win_next[0].viol
               && (win_next[0].pol == win_next[4].pol);
    hdb3_hit = is_viol(win_next[0])
               && !is_mark(win_next[1]) && !is_mark(win_next[2])
               && (!is_mark(win_next[3])
                   || (!win_next[3].viol && (win_next[3].pol == win_next[0].pol)));
    if ((code == LCD_B8ZS) && b8zs_hit) begin
      for (int i = 0; i < LCD_WIN_DEPTH; i++) begin
        win_next[i] = '0;
      end
    end else if ((code == LCD_HDB3) && hdb3_hit) begin
      for (int i = 0; i < 4; i++) begin
        win_next[i] = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  always_comb begin
    case (code)
      LCD_AMI: begin
        if (zero_limit_standard_select_i) begin
          exz_limit = LCD_EXZ_AMI_FCC;
        end else begin
          exz_limit = LCD_EXZ_AMI_ANSI;
        end
      end
      LCD_B8ZS: begin
        exz_limit = LCD_EXZ_B8ZS;
      end
      LCD_HDB3: begin
        exz_limit = LCD_EXZ_HDB3;
      end
      default: begin
        exz_limit = LCD_EXZ_AMI_ANSI;
      end
    endcase
    if (sym_in.mark) begin
      zrun_next = 7'h00;
    end else begin
      zrun_next = sat_inc(zrun_reg);
    end
    bpv_now   = bit_en_i && (code == LCD_AMI) && sym_in.viol;
    cv_now    = 1'b0;
    if (bit_en_i && is_viol(sym_out)) begin
      if (code == LCD_B8ZS) begin
        cv_now = 1'b1;
      end else if (code == LCD_HDB3) begin
        cv_now = hdb_viol_reg;
      end
    end
    exz_now = bit_en_i && !sym_in.mark && (zrun_next == exz_limit + 7'h01);
  end

  // ----------------------------------------------------------------
  // Decoder state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < LCD_WIN_DEPTH; i++) begin
        win_reg[i] <= '0;
      end
      last_pol_reg <= 1'b0;
      hdb_viol_reg <= 1'b0;
      zrun_reg     <= 7'h00;
    end else if (bit_en_i) begin
      for (int i = 0; i < LCD_WIN_DEPTH; i++) begin
        win_reg[i] <= win_next[i];
      end
      if (sym_in.mark) begin
        last_pol_reg <= sym_in.pol;
      end
      if (sym_out.mark) begin
        hdb_viol_reg <= sym_out.viol;
      end
      zrun_reg <= zrun_next;
    end
  end

  // ----------------------------------------------------------------
  // Decoded data and event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      data_o       <= 1'b0;
      data_valid_o <= 1'b0;
      bpv_event_o  <= 1'b0;
      cv_event_o   <= 1'b0;
      exz_event_o  <= 1'b0;
    end else begin
      data_valid_o <= bit_en_i;
      bpv_event_o  <= bpv_now;
      cv_event_o   <= cv_now;
      exz_event_o  <= exz_now;
      if (bit_en_i) begin
        data_o <= sym_out.mark || (los_w && all_ones_insert_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero-run error counter
  // ----------------------------------------------------------------
  always_comb begin
    count_ev = exz_now && (error_count_select_i == LCD_COUNT_ON);
    if (report_mode_select_i) begin
      copy_now = second_tick_i;
    end else begin
      copy_now = count_transfer_request_i && !trf_prev_reg;
    end
    ovf_now  = count_ev && !copy_now && (&count_reg);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trf_prev_reg <= 1'b0;
    end else begin
      trf_prev_reg <= count_transfer_request_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count_low_o  <= LCD_COUNT_RESET;
      count_high_o <= LCD_COUNT_RESET;
    end else if (copy_now) begin
      count_low_o  <= count_reg[COUNT_WIDTH/2-1:0];
      count_high_o <= count_reg[COUNT_WIDTH-1:COUNT_WIDTH/2];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (copy_now) begin
      count_reg <= {{(COUNT_WIDTH-1){1'b0}}, count_ev};
    end else if (count_ev) begin
      count_reg <= count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Loss of signal
  // ----------------------------------------------------------------
  lcd_los_monitor i_lcd_los_monitor (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .bit_en_i   (bit_en_i),
    .e1_mode_i  (e1_mode_i),
    .criteria_i (signal_loss_criteria_select_i),
    .amp_low_i  (amp_low_i),
    .amp_ok_i   (amp_ok_i),
    .mark_i     (sym_in.mark),
    .los_o      (los_w)
  );

  assign signal_loss_state_o = los_w;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      los_prev_reg <= 1'b0;
    end else begin
      los_prev_reg <= los_w;
    end
  end

  always_comb begin
    if (signal_loss_edge_select_i) begin
      los_edge = (los_w != los_prev_reg);
    end else begin
      los_edge = los_w && !los_prev_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    set_now.count_overflow = ovf_now;
    set_now.violation      = bpv_now || cv_now;
    set_now.zero_run       = exz_now;
    set_now.signal_loss    = los_edge;
    status_next = set_now | (status_o & ~status_clear_i);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else begin
      status_o <= status_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_next & irq_enable_i);
    end
  end

endmodule

/* verif/lcd_cdr_model.sv */
// Behavioural receive front end presenting one line symbol per bit strobe.
`timescale 1ns/10ps
module lcd_cdr_model (
  input  wire logic clock_i,
  output logic      bit_en_o,
  output logic      rx_pos_o,
  output logic      rx_neg_o,
  output logic      amp_low_o,
  output logic      amp_ok_o
);
  initial begin
    bit_en_o  = 1'b0;
    rx_pos_o  = 1'b0;
    rx_neg_o  = 1'b0;
    amp_low_o = 1'b0;
    amp_ok_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Symbol transfer
  // ----------------------------------------------------------------
  // Holds one symbol up to its sampling edge, then scrambles the idle lines.
  task automatic send(input logic p, input logic n, input logic lo, input logic ok);
    @(posedge clock_i);
    bit_en_o  <= 1'b1;
    rx_pos_o  <= p;
    rx_neg_o  <= n;
    amp_low_o <= lo;
    amp_ok_o  <= ok;
    @(posedge clock_i);
    bit_en_o  <= 1'b0;
    rx_pos_o  <= ~p;
    rx_neg_o  <= ~n;
  endtask
endmodule

/* verif/lcd_line_decoder_sva.sv */
// Port-level assertions for the line decoder.
`timescale 1ns/10ps
module lcd_line_decoder_sva
  import lcd_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)
(
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  input wire logic                   bit_en_i,
  input wire logic                   line_code_select_i,
  input wire logic                   report_mode_select_i,
  input wire logic                   count_transfer_request_i,
  input wire logic                   second_tick_i,
  input wire logic                   signal_loss_edge_select_i,
  input wire logic                   all_ones_insert_i,
  input wire lcd_flags_t             irq_enable_i,
  input wire logic                   data_o,
  input wire logic                   data_valid_o,
  input wire logic                   bpv_event_o,
  input wire logic                   cv_event_o,
  input wire logic                   exz_event_o,
  input wire logic [COUNT_WIDTH/2-1:0] count_low_o,
  input wire logic [COUNT_WIDTH/2-1:0] count_high_o,
  input wire lcd_flags_t             status_o,
  input wire logic                   signal_loss_state_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic       req_q;
  logic       copy_q;
  logic [3:0] lost_bits;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      req_q  <= 1'b0;
      copy_q <= 1'b0;
    end else begin
      req_q  <= count_transfer_request_i;
      copy_q <= report_mode_select_i ? second_tick_i : count_transfer_request_i & ~req_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !signal_loss_state_o) begin
      lost_bits <= 4'h0;
    end else if (bit_en_i && lost_bits != 4'hF) begin
      lost_bits <= lost_bits + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_BPV_AMI: assert property (bpv_event_o |-> $past(bit_en_i) && !$past(line_code_select_i))
    else $error("bipolar violation outside an AMI bit");
  AST_CV_CODED: assert property (cv_event_o |-> $past(bit_en_i) && $past(line_code_select_i))
    else $error("code violation outside a coded bit");
  AST_VALID_BIT: assert property (bit_en_i |=> data_valid_o)
    else $error("received bit gave no valid output");
  AST_EXZ_SET: assert property (exz_event_o |-> status_o.zero_run)
    else $error("zero run status not set");
  AST_VIOL_SET: assert property (bpv_event_o || cv_event_o |-> status_o.violation)
    else $error("violation status not set");
  AST_IRQ_MASK: assert property (irq_o == |(status_o & $past(irq_enable_i)))
    else $error("interrupt differs from enabled status");
  AST_COPY_ONLY: assert property ($changed({count_high_o, count_low_o}) |-> copy_q)
    else $error("count registers changed without a copy");
  AST_LOS_RISE: assert property ($rose(signal_loss_state_o) |=> status_o.signal_loss)
    else $error("loss event not set on rising state");
  AST_LOS_FALL: assert property ($fell(signal_loss_state_o) && signal_loss_edge_select_i
    |=> status_o.signal_loss) else $error("loss event not set on falling state");
  AST_LOS_STEP: assert property ($changed(signal_loss_state_o) |-> $past(bit_en_i))
    else $error("loss state moved between bits");
  AST_ONES_FILL: assert property (data_valid_o && signal_loss_state_o && all_ones_insert_i
    && lost_bits > 4'h9 |-> data_o) else $error("zero delivered during loss with fill on");
endmodule

/* verif/tb_lcd_line_decoder.sv */
// Self-checking bench for the line decoder with a behavioural front end.
`timescale 1ns/10ps
module tb_lcd_line_decoder
  import lcd_pkg::*;
;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       bit_en_i, rx_pos_i, rx_neg_i, amp_low_i, amp_ok_i;
  logic       e1_mode_i = 1'b0, line_code_select_i = 1'b0, zero_limit_standard_select_i = 1'b0;
  logic [1:0] error_count_select_i = 2'h1;
  logic       report_mode_select_i = 1'b0, count_transfer_request_i = 1'b0, second_tick_i = 1'b0;
  logic       signal_loss_criteria_select_i = 1'b0, signal_loss_edge_select_i = 1'b0;
  logic       all_ones_insert_i = 1'b0;
  lcd_flags_t irq_enable_i = 4'h4, status_clear_i = 4'h0;
  logic       data_o, data_valid_o, bpv_event_o, cv_event_o, exz_event_o, irq_o;
  logic [7:0] count_low_o, count_high_o;
  lcd_flags_t status_o;
  logic       signal_loss_state_o;
  logic       pol = 1'b0, lo = 1'b0, ok = 1'b0;
  logic [1:0] mode_tab [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
  logic       zsel_tab [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int         lim_tab [5] = '{15, 80, 7, 3, 15};
  int         fails = 0, total_checks = 0, cyc = 0, bpv_n = 0, cv_n = 0, exz_n = 0, one_n = 0;

  lcd_cdr_model i_lcd_cdr_model (
    .clock_i  (clock_i),
    .bit_en_o (bit_en_i),
    .rx_pos_o (rx_pos_i),
    .rx_neg_o (rx_neg_i),
    .amp_low_o(amp_low_i),
    .amp_ok_o (amp_ok_i)
  );

  lcd_line_decoder #(.COUNT_WIDTH(16)) i_lcd_line_decoder (
    .clock_i, .rst_n_i, .bit_en_i, .rx_pos_i, .rx_neg_i, .e1_mode_i, .line_code_select_i,
    .zero_limit_standard_select_i, .error_count_select_i, .report_mode_select_i,
    .count_transfer_request_i, .second_tick_i, .signal_loss_criteria_select_i,
    .signal_loss_edge_select_i, .all_ones_insert_i, .amp_low_i, .amp_ok_i, .irq_enable_i,
    .status_clear_i, .data_o, .data_valid_o, .bpv_event_o, .cv_event_o, .exz_event_o,
    .count_low_o, .count_high_o, .status_o, .signal_loss_state_o, .irq_o
  );

  initial forever #12.5 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // Event tally and timeout
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (bpv_event_o === 1'b1) bpv_n <= bpv_n + 1;
    if (cv_event_o === 1'b1) cv_n <= cv_n + 1;
    if (exz_event_o === 1'b1) exz_n <= exz_n + 1;
    if (data_valid_o === 1'b1 && data_o === 1'b1) one_n <= one_n + 1;
    if (cyc == 10000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Sends a zero (0), an alternating mark (1) or a mark repeating the last polarity (2).
  task automatic sym(input int k);
    if (k == 1) pol = ~pol;
    i_lcd_cdr_model.send((k != 0) & pol, (k != 0) & ~pol, lo, ok);
  endtask

  task automatic zeros(input int n);
    repeat (n) sym(0);
  endtask

  task automatic flush();
    repeat (9) sym(1);
  endtask

  task automatic win(input int n, input int step);
    for (int i = 0; i < n; i++) sym((i % step == 0) ? 1 : 0);
    wt(3);
  endtask

  task automatic sclr(input lcd_flags_t m);
    @(posedge clock_i);
    status_clear_i <= m;
    @(posedge clock_i);
    status_clear_i <= 4'h0;
    wt(2);
  endtask

  task automatic xfer(input logic [15:0] exp);
    @(posedge clock_i);
    count_transfer_request_i <= ~report_mode_select_i;
    second_tick_i            <= report_mode_select_i;
    @(posedge clock_i);
    count_transfer_request_i <= 1'b0;
    second_tick_i            <= 1'b0;
    wt(2);
    chk({count_high_o, count_low_o}, exp);
  endtask

  task automatic los_run(input int n);
    lo = 1'b1;
    ok = 1'b0;
    zeros(n - 1);
    wt(2);
    chk(16'(signal_loss_state_o), 16'h0000);
    sym(0);
    wt(2);
    chk(16'({status_o.signal_loss, signal_loss_state_o}), 16'h0003);
    lo = 1'b0;
    ok = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int b;
    int c;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wt(1);
    chk({count_high_o, count_low_o}, 16'h0000);
    chk(16'({status_o, signal_loss_state_o, irq_o}), 16'h0000);
    sym(1);
    sym(2);
    wt(2);
    chk(16'(bpv_n), 16'h0001);
    chk(16'({status_o.violation, irq_o}), 16'h0003);
    sclr(4'h4);
    chk(16'({status_o.violation, irq_o}), 16'h0000);
    for (int j = 0; j < 5; j++) begin
      @(posedge clock_i);
      {e1_mode_i, line_code_select_i} <= mode_tab[j];
      zero_limit_standard_select_i    <= zsel_tab[j];
      b = exz_n;
      sym(1);
      zeros(lim_tab[j]);
      wt(2);
      chk(16'(exz_n - b), 16'h0000);
      sym(0);
      wt(2);
      chk(16'(exz_n - b), 16'h0001);
      flush();
    end
    chk(16'({status_o.zero_run, irq_o}), 16'h0002);
    xfer(16'h0005);
    xfer(16'h0000);
    @(posedge clock_i);
    error_count_select_i <= 2'h2;
    sym(1);
    zeros(16);
    xfer(16'h0000);
    @(posedge clock_i);
    error_count_select_i <= 2'h1;
    report_mode_select_i <= 1'b1;
    sym(1);
    zeros(16);
    xfer(16'h0001);
    @(posedge clock_i);
    {e1_mode_i, line_code_select_i} <= 2'h1;
    flush();
    wt(2);
    b = one_n;
    c = cv_n;
    sym(1);
    zeros(3);
    sym(2);
    sym(1);
    sym(0);
    sym(2);
    sym(1);
    flush();
    wt(2);
    chk(16'(one_n - b), 16'h000A);
    chk(16'(cv_n - c), 16'h0000);
    c = cv_n;
    sym(2);
    flush();
    wt(2);
    chk(16'(cv_n - c), 16'h0001);
    @(posedge clock_i);
    {e1_mode_i, line_code_select_i} <= 2'h3;
    flush();
    c = cv_n;
    sym(2);
    sym(2);
    flush();
    wt(2);
    chk(16'(cv_n - c), 16'h0001);
    b = one_n;
    c = cv_n;
    sym(1);
    zeros(3);
    sym(2);
    flush();
    wt(2);
    chk(16'(one_n - b), 16'h000A);
    chk(16'(cv_n - c), 16'h0000);
    @(posedge clock_i);
    {e1_mode_i, line_code_select_i} <= 2'h0;
    all_ones_insert_i               <= 1'b1;
    los_run(175);
    sclr(4'h1);
    win(128, 9);
    chk(16'({status_o.signal_loss, signal_loss_state_o}), 16'h0001);
    win(128, 4);
    chk(16'({status_o.signal_loss, signal_loss_state_o}), 16'h0000);
    @(posedge clock_i);
    e1_mode_i                 <= 1'b1;
    signal_loss_edge_select_i <= 1'b1;
    los_run(32);
    sclr(4'h1);
    win(32, 8);
    chk(16'({status_o.signal_loss, signal_loss_state_o}), 16'h0002);
    @(posedge clock_i);
    e1_mode_i                     <= 1'b0;
    signal_loss_criteria_select_i <= 1'b1;
    sclr(4'h1);
    los_run(1544);
    report_and_stop();
  end
endmodule

bind lcd_line_decoder lcd_line_decoder_sva #(.COUNT_WIDTH(COUNT_WIDTH))
  i_lcd_line_decoder_sva (.*);
